// >>> rtl/gyro_config_status_regs.sv
`timescale 1ns/1ps
`default_nettype none

`include "gyro_cfg_regs.svh"

module gyro_config_status_regs
   import gyro_cfg_pkg::*;
#(
   parameter int MS_CYCLES = `MS_IN_PS / `CLK_PERIOD_PS,
   parameter int QUEUE_DEPTH = 100
) (
   input wire logic sys_clk, // system clock, 200 MHz
   input wire logic rst_n, // sync reset, active low
   input wire logic [7:0] regAddr, // register offset
   input wire logic [7:0] regWrData, // write data
   input wire logic regWrEn, // write strobe
   input wire logic regRdEn, // read strobe
   output logic [7:0] regRdData, // read data
   output logic regRdValid, // read data valid pulse
   input wire logic highRateEvent, // high-rate event pulse
   input wire logic highRateSign, // event sign, 1 positive
   input wire logic [2:0] highRateAxis, // z,y,x trigger flags
   input wire logic frameStored, // frame entered the queue
   input wire logic frameRead, // frame left the queue
   input wire logic queueCfgWr, // buffer configuration written
   input wire logic threeWireSerial, // serial port in 3-wire mode
   output logic [2:0] rangeCode, // active full-scale code
   output logic [11:0] countsPerDpsX10, // scaling, tenths
   output logic [10:0] outRateHz, // output data rate
   output logic [9:0] filterBwHz, // filter bandwidth
   output logic filterBypass, // unfiltered output
   output power_state_t powerState, // current power state
   output logic driveOn, // sensor drive enable
   output logic trigFirstIrqPin, // trigger from first irq pin
   output logic trigSecondIrqPin, // trigger from second irq pin
   output logic trigSerialOutPin // trigger from serial out pin
);

   // ----------------------------------------------------------------
   // configuration state
   // ----------------------------------------------------------------
   logic [2:0] range_q, range_d;
   logic [3:0] filter_q, filter_d;
   logic suspend_q, suspend_d;
   logic deep_q, deep_d;
   logic [2:0] sleepDur_q, sleepDur_d;
   logic fastPowerup_q, fastPowerup_d;
   logic powerSave_q, powerSave_d;
   logic [1:0] trigSel_q, trigSel_d;
   logic [2:0] autoDur_q, autoDur_d;

   logic wrRange, wrFilter, wrPower, wrWake;
   logic [7:0] detailByte, queueByte;

   assign wrRange = regWrEn && (regAddr == `FULL_SCALE_SELECT_OFFSET);
   assign wrFilter = regWrEn && (regAddr == `FILTER_RATE_SELECT_OFFSET);
   assign wrPower = regWrEn && (regAddr == `POWER_MODE_CTRL_OFFSET);
   assign wrWake = regWrEn && (regAddr == `WAKE_TRIGGER_CTRL_OFFSET);

   always_comb begin
      range_d = range_q;
      filter_d = filter_q;
      suspend_d = suspend_q;
      deep_d = deep_q;
      sleepDur_d = sleepDur_q;
      fastPowerup_d = fastPowerup_q;
      powerSave_d = powerSave_q;
      trigSel_d = trigSel_q;
      autoDur_d = autoDur_q;
      // settings are lost in deep suspend, so writes there other than power mode control are dropped
      if (!deep_q) begin
         if (wrRange && regWrData[2:0] <= `RANGE_MAX_CODE) begin
            range_d = regWrData[2:0];
         end
         if (wrFilter && !regWrData[`FILTER_RSVD_BIT]) begin
            filter_d = regWrData[3:0];
         end
         if (wrWake) begin
            fastPowerup_d = regWrData[`WAKE_FAST_BIT];
            powerSave_d = regWrData[`WAKE_PSAVE_BIT];
            trigSel_d = regWrData[`WAKE_TRIG_LSB +: 2];
            if (regWrData[2:0] != 3'h0) begin
               autoDur_d = regWrData[2:0];
            end
         end
      end
      if (wrPower) begin
         sleepDur_d = regWrData[`PWR_SLEEP_LSB +: 3];
         // both set is illegal, mode kept
         if (!(regWrData[`PWR_SUSPEND_BIT] && regWrData[`PWR_DEEP_BIT])) begin
            suspend_d = regWrData[`PWR_SUSPEND_BIT];
            deep_d = regWrData[`PWR_DEEP_BIT];
         end
         // leaving deep suspend brings the other settings back to defaults
         if (deep_q && !deep_d) begin
            range_d = `FULL_SCALE_RESET;
            filter_d = `FILTER_RESET;
            fastPowerup_d = 1'b0;
            powerSave_d = 1'b0;
            trigSel_d = `TRIG_RESET;
            autoDur_d = `AUTOSLEEP_RESET;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         range_q <= `FULL_SCALE_RESET;
         filter_q <= `FILTER_RESET;
         suspend_q <= 1'b0;
         deep_q <= 1'b0;
         sleepDur_q <= `SLEEP_DUR_RESET;
         fastPowerup_q <= 1'b0;
         powerSave_q <= 1'b0;
         trigSel_q <= `TRIG_RESET;
         autoDur_q <= `AUTOSLEEP_RESET;
      end else begin
         range_q <= range_d;
         filter_q <= filter_d;
         suspend_q <= suspend_d;
         deep_q <= deep_d;
         sleepDur_q <= sleepDur_d;
         fastPowerup_q <= fastPowerup_d;
         powerSave_q <= powerSave_d;
         trigSel_q <= trigSel_d;
         autoDur_q <= autoDur_d;
      end
   end

   // ----------------------------------------------------------------
   // event and queue status
   // ----------------------------------------------------------------
   event_status #(
      .DEPTH(QUEUE_DEPTH)
   ) u_status (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .highRateEvent(highRateEvent),
      .highRateSign(highRateSign),
      .highRateAxis(highRateAxis),
      .frameStored(frameStored),
      .frameRead(frameRead),
      .queueCfgWr(queueCfgWr),
      .detailByte(detailByte),
      .queueByte(queueByte)
   );

   // ----------------------------------------------------------------
   // power state sequencing
   // ----------------------------------------------------------------
   power_state_t pwr_q, pwr_d;
   logic timerLoad;
   logic [5:0] timerMs;
   logic timerExpired;

   always_comb begin
      pwr_d = pwr_q;
      timerLoad = 1'b0;
      timerMs = autoMs(autoDur_q);
      if (deep_q) begin
         pwr_d = PWR_DEEP;
      end else if (suspend_q) begin
         pwr_d = PWR_SUSPEND;
      end else if (!powerSave_q) begin
         pwr_d = PWR_NORMAL;
      end else begin
         unique case (pwr_q)
            PWR_PS_AWAKE: begin
               if (timerExpired) begin
                  pwr_d = PWR_PS_SLEEP;
                  timerLoad = 1'b1;
                  timerMs = sleepMs(sleepDur_q);
               end
            end
            PWR_PS_SLEEP: begin
               if (timerExpired) begin
                  pwr_d = PWR_PS_AWAKE;
                  timerLoad = 1'b1;
               end
            end
            default: begin
               pwr_d = PWR_PS_AWAKE;
               timerLoad = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pwr_q <= PWR_NORMAL;
      end else begin
         pwr_q <= pwr_d;
      end
   end

   ms_timer #(
      .MS_CYCLES(MS_CYCLES)
   ) u_timer (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .load(timerLoad),
      .loadMs(timerMs),
      .expired(timerExpired)
   );

   // ----------------------------------------------------------------
   // derived outputs, one cycle behind the configuration
   // ----------------------------------------------------------------
   logic [11:0] scale_d;
   logic [10:0] odr_d;
   logic [9:0] bw_d;
   logic drive_d;

   always_comb begin
      scale_d = scaleX10(range_q);
      unique case (filter_q[2:0])
         3'h7: begin odr_d = `ODR_100; bw_d = `BW_32; end
         3'h6: begin odr_d = `ODR_200; bw_d = `BW_64; end
         3'h5: begin odr_d = `ODR_100; bw_d = `BW_12; end
         3'h4: begin odr_d = `ODR_200; bw_d = `BW_23; end
         3'h3: begin odr_d = `ODR_400; bw_d = `BW_47; end
         3'h2: begin odr_d = `ODR_1000; bw_d = `BW_116; end
         3'h1: begin odr_d = `ODR_2000; bw_d = `BW_230; end
         default: begin odr_d = `ODR_2000; bw_d = `BW_UNFILTERED; end
      endcase
      unique case (pwr_q)
         PWR_SUSPEND: drive_d = fastPowerup_q;
         PWR_DEEP: drive_d = 1'b0;
         default: drive_d = 1'b1;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rangeCode <= `FULL_SCALE_RESET;
         countsPerDpsX10 <= `SCALE_WIDEST_X10;
         outRateHz <= `ODR_2000;
         filterBwHz <= `BW_UNFILTERED;
         filterBypass <= 1'b1;
         powerState <= PWR_NORMAL;
         driveOn <= 1'b1;
         trigFirstIrqPin <= 1'b0;
         trigSecondIrqPin <= 1'b0;
         trigSerialOutPin <= 1'b0;
      end else begin
         rangeCode <= range_q;
         countsPerDpsX10 <= scale_d;
         outRateHz <= odr_d;
         filterBwHz <= bw_d;
         filterBypass <= (filter_q == 4'h0);
         powerState <= pwr_q;
         driveOn <= drive_d;
         trigFirstIrqPin <= (trigSel_q == 2'h1);
         trigSecondIrqPin <= (trigSel_q == 2'h2);
         // serial out pin only serves as trigger in 3-wire mode
         trigSerialOutPin <= (trigSel_q == 2'h3) && threeWireSerial;
      end
   end

   // ----------------------------------------------------------------
   // register read-back
   // ----------------------------------------------------------------
   logic [7:0] rdData_d;

   always_comb begin
      unique case (regAddr)
         `HIGH_RATE_EVENT_DETAIL_OFFSET: rdData_d = detailByte;
         `QUEUE_STATE_OFFSET: rdData_d = queueByte;
         `FULL_SCALE_SELECT_OFFSET: rdData_d = {5'h0, range_q};
         `FILTER_RATE_SELECT_OFFSET: rdData_d = `FILTER_READ_FIXED | {4'h0, filter_q};
         `POWER_MODE_CTRL_OFFSET:
            rdData_d = {suspend_q, 1'b0, deep_q, 1'b0, sleepDur_q, 1'b0};
         `WAKE_TRIGGER_CTRL_OFFSET:
            rdData_d = {fastPowerup_q, powerSave_q, trigSel_q, 1'b0, autoDur_q};
         // unmapped offsets read as zero
         default: rdData_d = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         regRdData <= 8'h00;
         regRdValid <= 1'b0;
      end else begin
         regRdData <= regRdEn ? rdData_d : regRdData;
         regRdValid <= regRdEn;
      end
   end

endmodule : gyro_config_status_regs

`default_nettype wire

// >>> rtl/gyro_cfg_regs.svh
`ifndef GYRO_CFG_REGS_SVH
`define GYRO_CFG_REGS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define HIGH_RATE_EVENT_DETAIL_OFFSET 8'h0c
`define QUEUE_STATE_OFFSET 8'h0e
`define FULL_SCALE_SELECT_OFFSET 8'h0f
`define FILTER_RATE_SELECT_OFFSET 8'h10
`define POWER_MODE_CTRL_OFFSET 8'h11
`define WAKE_TRIGGER_CTRL_OFFSET 8'h12

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DETAIL_SIGN_BIT 3
`define QUEUE_OVERRUN_BIT 7
`define PWR_SUSPEND_BIT 7
`define PWR_DEEP_BIT 5
`define PWR_SLEEP_LSB 1
`define WAKE_FAST_BIT 7
`define WAKE_PSAVE_BIT 6
`define WAKE_TRIG_LSB 4
`define FILTER_RSVD_BIT 3

// ----------------------------------------------------------------
// reset values, fixed read bits and range limit
// ----------------------------------------------------------------
`define FULL_SCALE_RESET 3'h0
`define FILTER_RESET 4'h0
`define FILTER_READ_FIXED 8'h80
`define SLEEP_DUR_RESET 3'h0
`define AUTOSLEEP_RESET 3'h0
`define TRIG_RESET 2'h0
`define RANGE_MAX_CODE 3'h4

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_PS 5000
`define MS_IN_PS 1000000000
`define SLEEP_MS_0 6'd2
`define SLEEP_MS_1 6'd4
`define SLEEP_MS_2 6'd5
`define SLEEP_MS_3 6'd8
`define SLEEP_MS_4 6'd10
`define SLEEP_MS_5 6'd15
`define SLEEP_MS_6 6'd18
`define SLEEP_MS_7 6'd20
`define AUTO_MS_1 6'd4
`define AUTO_MS_2 6'd5
`define AUTO_MS_3 6'd8
`define AUTO_MS_4 6'd10
`define AUTO_MS_5 6'd15
`define AUTO_MS_6 6'd20
`define AUTO_MS_7 6'd40

// ----------------------------------------------------------------
// range scaling, tenths of counts per deg/s, and filter figures
// ----------------------------------------------------------------
`define SCALE_WIDEST_X10 12'd164
`define ODR_100 11'd100
`define ODR_200 11'd200
`define ODR_400 11'd400
`define ODR_1000 11'd1000
`define ODR_2000 11'd2000
`define BW_12 10'd12
`define BW_23 10'd23
`define BW_32 10'd32
`define BW_47 10'd47
`define BW_64 10'd64
`define BW_116 10'd116
`define BW_230 10'd230
`define BW_UNFILTERED 10'd523

`endif

// >>> rtl/gyro_cfg_pkg.sv
`include "gyro_cfg_regs.svh"

package gyro_cfg_pkg;

   typedef enum logic [4:0] {
      PWR_NORMAL = 5'b00001,
      PWR_SUSPEND = 5'b00010,
      PWR_DEEP = 5'b00100,
      PWR_PS_AWAKE = 5'b01000,
      PWR_PS_SLEEP = 5'b10000
   } power_state_t;

   function automatic logic [11:0] scaleX10(input logic [2:0] code);
      // each narrower step doubles; reserved codes never get stored
      scaleX10 = `SCALE_WIDEST_X10 << code;
   endfunction : scaleX10

   function automatic logic [5:0] sleepMs(input logic [2:0] code);
      unique case (code)
         3'h0: sleepMs = `SLEEP_MS_0;
         3'h1: sleepMs = `SLEEP_MS_1;
         3'h2: sleepMs = `SLEEP_MS_2;
         3'h3: sleepMs = `SLEEP_MS_3;
         3'h4: sleepMs = `SLEEP_MS_4;
         3'h5: sleepMs = `SLEEP_MS_5;
         3'h6: sleepMs = `SLEEP_MS_6;
         default: sleepMs = `SLEEP_MS_7;
      endcase
   endfunction : sleepMs

   function automatic logic [5:0] autoMs(input logic [2:0] code);
      unique case (code)
         3'h2: autoMs = `AUTO_MS_2;
         3'h3: autoMs = `AUTO_MS_3;
         3'h4: autoMs = `AUTO_MS_4;
         3'h5: autoMs = `AUTO_MS_5;
         3'h6: autoMs = `AUTO_MS_6;
         3'h7: autoMs = `AUTO_MS_7;
         // code 0 is the reset value but not allowed: run as code 1
         default: autoMs = `AUTO_MS_1;
      endcase
   endfunction : autoMs

endpackage : gyro_cfg_pkg

// >>> rtl/ms_timer.sv
`timescale 1ns/1ps
`default_nettype none

module ms_timer #(
   parameter int MS_CYCLES = 200000
) (
   input wire logic sys_clk, // system clock
   input wire logic rst_n, // sync reset, active low
   input wire logic load, // start a new interval
   input wire logic [5:0] loadMs, // interval length in ms
   output logic expired // one-cycle pulse at interval end
);

   logic [31:0] cycCnt_q, cycCnt_d;
   logic [5:0] msCnt_q, msCnt_d;
   logic run_q, run_d;
   logic expired_d;

   always_comb begin
      cycCnt_d = cycCnt_q;
      msCnt_d = msCnt_q;
      run_d = run_q;
      expired_d = 1'b0;
      if (load) begin
         cycCnt_d = 32'(MS_CYCLES - 1);
         msCnt_d = loadMs;
         run_d = 1'b1;
      end else if (run_q) begin
         if (cycCnt_q != 32'h0) begin
            cycCnt_d = cycCnt_q - 32'h1;
         end else if (msCnt_q > 6'h1) begin
            cycCnt_d = 32'(MS_CYCLES - 1);
            msCnt_d = msCnt_q - 6'h1;
         end else begin
            run_d = 1'b0;
            expired_d = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cycCnt_q <= 32'h0;
         msCnt_q <= 6'h0;
         run_q <= 1'b0;
         expired <= 1'b0;
      end else begin
         cycCnt_q <= cycCnt_d;
         msCnt_q <= msCnt_d;
         run_q <= run_d;
         expired <= expired_d;
      end
   end

endmodule : ms_timer

`default_nettype wire

// >>> rtl/event_status.sv
`timescale 1ns/1ps
`default_nettype none

module event_status #(
   parameter int DEPTH = 100
) (
   input wire logic sys_clk, // system clock
   input wire logic rst_n, // sync reset, active low
   input wire logic highRateEvent, // high-rate event pulse
   input wire logic highRateSign, // 1 positive rotation
   input wire logic [2:0] highRateAxis, // z,y,x trigger flags
   input wire logic frameStored, // frame written into queue
   input wire logic frameRead, // frame read out of queue
   input wire logic queueCfgWr, // buffer configuration written
   output logic [7:0] detailByte, // high-rate event detail
   output logic [7:0] queueByte // overrun flag and fill level
);

   logic [3:0] detail_q, detail_d;
   logic [6:0] level_q, level_d;
   logic overrun_q, overrun_d;
   logic full;

   assign full = (level_q == 7'(DEPTH));

   always_comb begin
      detail_d = detail_q;
      if (highRateEvent) begin
         detail_d = {highRateSign, highRateAxis};
      end
      level_d = queueCfgWr ? 7'h0 : level_q;
      if (frameStored && !frameRead && !full) begin
         level_d = level_d + 7'h1;
      end else if (frameRead && !frameStored && level_d != 7'h0) begin
         level_d = level_d - 7'h1;
      end
      overrun_d = queueCfgWr ? 1'b0 : overrun_q;
      if (frameStored && !frameRead && full) begin
         overrun_d = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         detail_q <= 4'h0;
         level_q <= 7'h0;
         overrun_q <= 1'b0;
         detailByte <= 8'h00;
         queueByte <= 8'h00;
      end else begin
         detail_q <= detail_d;
         level_q <= level_d;
         overrun_q <= overrun_d;
         detailByte <= {4'h0, detail_d};
         queueByte <= {overrun_d, level_d};
      end
   end

endmodule : event_status

`default_nettype wire

// >>> tb/gyro_regs_checker.sv
`timescale 1ns/1ps
`default_nettype none
module gyro_regs_checker
   import gyro_cfg_pkg::*;
(
   input wire logic sys_clk, // clock
   input wire logic rst_n, // reset
   input wire logic [7:0] regAddr, // offset
   input wire logic [7:0] regWrData, // wr data
   input wire logic regWrEn, // wr strobe
   input wire logic regRdEn, // rd strobe
   input wire logic [7:0] regRdData, // rd data
   input wire logic regRdValid, // rd valid
   input wire logic highRateEvent, // event
   input wire logic highRateSign, // sign
   input wire logic [2:0] highRateAxis, // axes
   input wire logic [2:0] rangeCode, // range
   input wire logic [11:0] countsPerDpsX10, // scale
   input wire logic [9:0] filterBwHz, // bandwidth
   input wire logic filterBypass, // bypass
   input wire power_state_t powerState, // state
   input wire logic driveOn, // drive
   input wire logic trigFirstIrqPin, // trig 1
   input wire logic trigSecondIrqPin, // trig 2
   input wire logic trigSerialOutPin // trig 3
);
   // ----
   // properties
   // ----
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   rd_answer_a: assert property (regRdEn |=> regRdValid)
      else $error("read without valid");
   rd_cause_a: assert property (regRdValid |-> $past(regRdEn))
      else $error("valid without read");
   range_legal_a: assert property (rangeCode <= 3'h4)
      else $error("reserved range code");
   scale_track_a: assert property (countsPerDpsX10 == (12'ha4 << rangeCode))
      else $error("scale off range");
   // read two cycles after a lone event shows its sign and axes
   detail_read_a: assert property (regRdEn && regAddr == 8'h0c && $past(highRateEvent, 2)
      && !$past(highRateEvent) && !highRateEvent
      |=> regRdData[3:0] == $past({highRateSign, highRateAxis}, 3))
      else $error("detail mismatch");
   deep_drive_a: assert property (powerState == PWR_DEEP && $past(powerState) == PWR_DEEP
      |-> !driveOn)
      else $error("drive on in deep");
   bypass_match_a: assert property (filterBypass == (filterBwHz == 10'h20b))
      else $error("bypass flag wrong");
   trig_onehot_a: assert property ($onehot0({trigFirstIrqPin, trigSecondIrqPin,
      trigSerialOutPin}))
      else $error("two trigger sources");
   suspend_entry_a: assert property (regWrEn && regAddr == 8'h11 && regWrData[7:5] == 3'h4
      && powerState == PWR_NORMAL |-> ##3 powerState == PWR_SUSPEND)
      else $error("suspend not entered");
   state_onehot_a: assert property ($onehot(powerState))
      else $error("state not one-hot");
endmodule : gyro_regs_checker

bind gyro_config_status_regs gyro_regs_checker chk (.sys_clk, .rst_n, .regAddr, .regWrData,
   .regWrEn, .regRdEn, .regRdData, .regRdValid, .highRateEvent, .highRateSign, .highRateAxis,
   .rangeCode, .countsPerDpsX10, .filterBwHz, .filterBypass, .powerState, .driveOn,
   .trigFirstIrqPin, .trigSecondIrqPin, .trigSerialOutPin);
`default_nettype wire

// >>> tb/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input wire logic sys_clk, // clock
   input wire logic [7:0] regRdData, // rd data
   input wire logic regRdValid, // rd valid
   output logic [7:0] regAddr, // offset
   output logic [7:0] regWrData, // wr data
   output logic regWrEn, // wr strobe
   output logic regRdEn // rd strobe
);
   // ----
   // register port
   // ----
   logic [7:0] rangeQ = 8'h00;
   initial begin
      regAddr = 8'h00;
      regWrData = 8'h00;
      regWrEn = 1'b0;
      regRdEn = 1'b0;
   end
   // idle lines show the inverse so stale values are never trusted
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regWrData <= d;
      regWrEn <= 1'b1;
      if (a == 8'h0f && d <= 8'h04) rangeQ <= d;
      @(posedge sys_clk);
      regWrEn <= 1'b0;
      regAddr <= ~a;
      regWrData <= ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      int n;
      @(posedge sys_clk);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge sys_clk);
      regRdEn <= 1'b0;
      regAddr <= ~a;
      for (n = 0; n < 4 && regRdValid !== 1'b1; n++) @(posedge sys_clk);
      d = regRdValid === 1'b1 ? regRdData : 8'hxx;
   endtask : rd
   // legal exit, rewrite range, zero reserved
   task automatic leave_deep();
      wr(8'h11, 8'h00);
      repeat (3) @(posedge sys_clk);
      wr(8'h0f, rangeQ & 8'h07);
   endtask : leave_deep
endmodule : host_model
`default_nettype wire

// >>> tb/gyro_config_status_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module gyro_config_status_regs_tb_top
   import gyro_cfg_pkg::*;
;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] regAddr, regWrData, regRdData, rdv;
   logic regWrEn, regRdEn, regRdValid, filterBypass, driveOn, trigA, trigB, trigC;
   logic highRateEvent = 1'b0, highRateSign = 1'b0, frameStored = 1'b0, frameRead = 1'b0;
   logic queueCfgWr = 1'b0, threeWireSerial = 1'b1;
   logic [2:0] highRateAxis = 3'h0, rangeCode;
   logic [11:0] countsPerDpsX10;
   logic [10:0] outRateHz;
   logic [9:0] filterBwHz;
   power_state_t powerState;
   int fail_count = 0, n_checks = 0;
   gyro_config_status_regs #(.MS_CYCLES(10), .QUEUE_DEPTH(4)) dut (.sys_clk, .rst_n, .regAddr,
      .regWrData, .regWrEn, .regRdEn, .regRdData, .regRdValid, .highRateEvent, .highRateSign,
      .highRateAxis, .frameStored, .frameRead, .queueCfgWr, .threeWireSerial, .rangeCode,
      .countsPerDpsX10, .outRateHz, .filterBwHz, .filterBypass, .powerState, .driveOn,
      .trigFirstIrqPin(trigA), .trigSecondIrqPin(trigB), .trigSerialOutPin(trigC));
   host_model host (.sys_clk, .regRdData, .regRdValid, .regAddr, .regWrData, .regWrEn, .regRdEn);
   // ----
   // helpers
   // ----
   initial begin
      forever #2.5 sys_clk = ~sys_clk;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t %s: got %h want %h", $time, what, seen, exp);
      end
   endtask : check
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : cyc
   // which: 0 store, 1 read out, 2 queue reconfigure
   task automatic strobe(input int which, input int n);
      repeat (n) begin
         @(posedge sys_clk);
         {queueCfgWr, frameRead, frameStored} <= 3'(1 << which);
         @(posedge sys_clk);
         {queueCfgWr, frameRead, frameStored} <= 3'h0;
      end
   endtask : strobe
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : stop_test
   // ----
   // scenarios
   // ----
   task automatic t_reset();
      logic [7:0] a [5] = '{8'h0f, 8'h10, 8'h11, 8'h12, 8'h20};
      logic [7:0] e [5] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00};
      for (int i = 0; i < 5; i++) begin
         host.rd(a[i], rdv);
         check(16'(rdv), 16'(e[i]), "reset read");
      end
      check(16'(countsPerDpsX10), 16'h00a4, "reset scale");
      check({4'h0, filterBypass, outRateHz}, 16'h0fd0, "reset rate");
      $display("reset test done");
   endtask : t_reset
   task automatic t_range();
      for (int c = 0; c < 6; c++) begin
         host.wr(8'h0f, 8'(c));
         cyc(3);
         check(16'(rangeCode), 16'(c < 5 ? c : 4), "range");
         check(16'(countsPerDpsX10), 16'(12'ha4 << (c < 5 ? c : 4)), "scale");
      end
      $display("range test done");
   endtask : t_range
   task automatic t_filter();
      int odr [8] = '{2000, 2000, 1000, 400, 200, 100, 200, 100};
      int bw [8] = '{523, 230, 116, 47, 23, 12, 64, 32};
      for (int c = 7; c >= 0; c--) begin
         host.wr(8'h10, 8'(c));
         cyc(3);
         check(16'(outRateHz), 16'(odr[c]), "rate");
         check(16'(filterBwHz), 16'(bw[c]), "bandwidth");
         check(16'(filterBypass), 16'(c == 0), "bypass");
      end
      host.wr(8'h10, 8'h0f);
      host.rd(8'h10, rdv);
      check(16'(rdv), 16'h0080, "reserved filter");
      $display("filter test done");
   endtask : t_filter
   task automatic t_event();
      logic [3:0] v [2] = '{4'hc, 4'h3};
      for (int i = 0; i < 2; i++) begin
         @(posedge sys_clk);
         highRateEvent <= 1'b1;
         {highRateSign, highRateAxis} <= v[i];
         @(posedge sys_clk);
         highRateEvent <= 1'b0;
         {highRateSign, highRateAxis} <= ~v[i];
         host.rd(8'h0c, rdv);
         check(16'(rdv[3:0]), 16'(v[i]), "event detail");
      end
      $display("event test done");
   endtask : t_event
   task automatic t_queue();
      strobe(0, 5);
      host.rd(8'h0e, rdv);
      check(16'(rdv), 16'h0084, "overrun full");
      strobe(1, 1);
      host.wr(8'h0e, 8'h00);
      host.rd(8'h0e, rdv);
      check(16'(rdv), 16'h0083, "overrun sticks");
      strobe(1, 3);
      host.rd(8'h0e, rdv);
      check(16'(rdv), 16'h0080, "drained");
      strobe(2, 1);
      host.rd(8'h0e, rdv);
      check(16'(rdv), 16'h0000, "cleared");
      $display("queue test done");
   endtask : t_queue
   task automatic t_power();
      host.wr(8'h11, 8'h80);
      cyc(4);
      check(16'(powerState), 16'(PWR_SUSPEND), "suspend");
      check(16'(driveOn), 16'h0000, "drive off");
      host.wr(8'h12, 8'h81);
      cyc(4);
      check(16'(driveOn), 16'h0001, "drive kept");
      host.wr(8'h11, 8'h00);
      host.wr(8'h11, 8'ha6);
      cyc(4);
      check(16'(powerState), 16'(PWR_NORMAL), "illegal mode");
      host.rd(8'h11, rdv);
      check(16'(rdv), 16'h0006, "sleep field");
      host.wr(8'h0f, 8'h02);
      host.wr(8'h11, 8'h20);
      cyc(4);
      check(16'(powerState), 16'(PWR_DEEP), "deep");
      check(16'(driveOn), 16'h0000, "deep drive");
      host.leave_deep();
      cyc(3);
      check(16'(rangeCode), 16'h0002, "range restored");
      host.rd(8'h12, rdv);
      check(16'(rdv), 16'h0000, "defaults back");
      $display("power test done");
   endtask : t_power
   // alternation spans at ten cycles per ms
   task automatic t_psave();
      int n;
      host.wr(8'h12, 8'h41);
      for (n = 0; n < 100 && powerState !== PWR_PS_SLEEP; n++) @(posedge sys_clk);
      check(16'(n >= 40 && n <= 46), 16'h0001, "awake span");
      for (n = 0; n < 100 && powerState !== PWR_PS_AWAKE; n++) @(posedge sys_clk);
      check(16'(n >= 20 && n <= 24), 16'h0001, "sleep span");
      host.wr(8'h12, 8'h00);
      cyc(4);
      check(16'(powerState), 16'(PWR_NORMAL), "save off");
      host.rd(8'h12, rdv);
      check(16'(rdv), 16'h0001, "autosleep kept");
      $display("power save test done");
   endtask : t_psave
   task automatic t_trig();
      for (int c = 0; c < 4; c++) begin
         host.wr(8'h12, 8'(c << 4));
         cyc(3);
         check({13'h0, trigC, trigB, trigA}, 16'(c == 0 ? 0 : 1 << (c - 1)), "trigger");
      end
      threeWireSerial <= 1'b0;
      cyc(3);
      check(16'(trigC), 16'h0000, "four-wire mode");
      $display("trigger test done");
   endtask : t_trig
   initial begin
      repeat (20000) @(posedge sys_clk);
      fail_count++;
      stop_test();
   end
   initial begin
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_reset();
      t_range();
      t_filter();
      t_event();
      t_queue();
      t_power();
      t_psave();
      t_trig();
      stop_test();
   end
endmodule : gyro_config_status_regs_tb_top
`default_nettype wire
